//--- adc_seq_regs.svh
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH
// register byte offsets
`define OFS_CTL_ONE 8'h00
`define OFS_CTL_TWO 8'h04
`define OFS_CLK_TIM 8'h08
`define OFS_MUX_SEL 8'h0c
// converter_control_one fields
`define C1_ON 15
`define C1_FORM_HI 10
`define C1_FORM_LO 8
`define C1_TRIG_HI 7
`define C1_TRIG_LO 5
`define C1_STOP 4
`define C1_AUTO 2
`define C1_SAMPLE_ENABLE 1
`define C1_DONE 0
// converter_control_two fields
`define C2_REF_HI 15
`define C2_REF_LO 13
`define C2_OFFSET_CALIBRATION 12
`define C2_SCAN 10
`define C2_FILL 7
`define C2_SPI_HI 5
`define C2_SPI_LO 2
`define C2_SPLIT 1
`define C2_ALT 0
// converter_clock_timing fields
`define CT_SRC 15
`define CT_AUTO_SAMPLE_TIME_HI 12
`define CT_AUTO_SAMPLE_TIME_LO 8
`define CT_DIV_HI 7
`define CT_DIV_LO 0
// input_mux_select fields
`define MX_NEG_B 31
`define MX_POS_B_HI 28
`define MX_POS_B_LO 24
`define MX_NEG_A 23
`define MX_POS_A_HI 20
`define MX_POS_A_LO 16
// reset values
`define RST_WORD 32'h0000_0000
// trigger source codes
`define TRIG_SOFT 3'h0
`define TRIG_EXT_PIN 3'h1
`define TRIG_TIMER 3'h2
`define TRIG_CHARGE 3'h3
`define TRIG_COUNTER 3'h7
`endif

//--- adc_seq_pkg.sv
package adc_seq_pkg;
   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONVERT = 2'b10
   } seq_state_e;
   typedef logic [31:0] word_t;
endpackage

//--- adc_sequence_control.sv
// Implementation choices: the AHB-Lite slave port and the register offsets.
`include "adc_seq_regs.svh"
module adc_sequence_control (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // trigger sources
   input wire logic ext_int_pin,
   input wire logic timer_match,
   input wire logic charge_unit_trig,
   input wire logic internal_rc_clock,
   // analog core
   input wire logic conv_done_pin,
   output logic sampling,
   output logic conv_start,
   output logic conv_clock,
   output logic [2:0] result_format,
   output logic vrefh_external,
   output logic vrefl_external,
   output logic inputs_to_vrefl,
   output logic [4:0] positive_select,
   output logic negative_select,
   output logic scan_active,
   output logic scan_advance,
   // result buffer and event
   output logic result_write,
   output logic [3:0] result_index,
   output logic seq_irq
);
   // ************************************************
   // registers and state
   // ************************************************
   adc_seq_pkg::seq_state_e state_r, state_nxt;
   logic on_r, stop_r, auto_r, done_r, split_r, alt_r, offset_calibration_r, scan_r;
   logic fill_r, use_b_r, src_r, neg_b_r, neg_a_r;
   logic [2:0] form_r, trig_r, ref_r;
   logic [3:0] spi_r, seq_cnt_r, idx_r;
   logic [4:0] auto_sample_time_r, sample_enable_cnt_r, pos_b_r, pos_a_r;
   logic [7:0] div_r, div_cnt_r;
   logic wr_pend_r;
   logic [7:0] wr_addr_r, rd_addr_r;
   logic rd_pend_r;
   logic [2:0] sync_r [3];
   logic [2:0] lvl_r;
   logic conv_clk_r;

   // ************************************************
   // helper functions
   // ************************************************
   // reference decode
   function automatic logic [1:0] ref_decode(input logic [2:0] code);
      if (code[2]) begin
         ref_decode = 2'b00;
      end else begin
         ref_decode = {code[1], code[0]};
      end
   endfunction

   // next entry within the active region
   function automatic logic [3:0] next_idx(input logic [3:0] i, input logic split);
      logic [3:0] n;
      n = i + 4'h1;
      if (split) begin
         next_idx = {i[3], n[2:0]};
      end else begin
         next_idx = n;
      end
   endfunction

   // ************************************************
   // bus decode
   // ************************************************
   logic addr_ok, wr_ctl1, wr_ctl2, wr_tim, wr_mux;
   assign addr_ok = hsel && htrans[1] && hready;
   assign wr_ctl1 = wr_pend_r && (wr_addr_r == `OFS_CTL_ONE);
   assign wr_ctl2 = wr_pend_r && (wr_addr_r == `OFS_CTL_TWO);
   assign wr_tim = wr_pend_r && (wr_addr_r == `OFS_CLK_TIM);
   assign wr_mux = wr_pend_r && (wr_addr_r == `OFS_MUX_SEL);

   // address phase capture; every read takes one wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         rd_addr_r <= 8'h00;
         hreadyout <= 1'b1;
      end else begin
         wr_pend_r <= addr_ok && hwrite && (hsize == 3'h2) && (haddr[31:8] == 24'h000000);
         rd_pend_r <= addr_ok && !hwrite;
         hreadyout <= !(addr_ok && !hwrite);
         if (addr_ok) begin
            wr_addr_r <= haddr[7:0];
            rd_addr_r <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hff;
         end
      end
   end

   // read data; unmapped addresses read as zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= `RST_WORD;
         hresp <= 1'b0;
      end else if (rd_pend_r) begin
         hrdata <= `RST_WORD;
         unique case (rd_addr_r)
            `OFS_CTL_ONE: begin
               hrdata[`C1_ON] <= on_r;
               hrdata[`C1_FORM_HI:`C1_FORM_LO] <= form_r;
               hrdata[`C1_TRIG_HI:`C1_TRIG_LO] <= trig_r;
               hrdata[`C1_STOP] <= stop_r;
               hrdata[`C1_AUTO] <= auto_r;
               hrdata[`C1_SAMPLE_ENABLE] <= (state_r == adc_seq_pkg::ST_SAMPLE);
               hrdata[`C1_DONE] <= done_r;
            end
            `OFS_CTL_TWO: begin
               hrdata[`C2_REF_HI:`C2_REF_LO] <= ref_r;
               hrdata[`C2_OFFSET_CALIBRATION] <= offset_calibration_r;
               hrdata[`C2_SCAN] <= scan_r;
               hrdata[`C2_FILL] <= fill_r;
               hrdata[`C2_SPI_HI:`C2_SPI_LO] <= spi_r;
               hrdata[`C2_SPLIT] <= split_r;
               hrdata[`C2_ALT] <= alt_r;
            end
            `OFS_CLK_TIM: begin
               hrdata[`CT_SRC] <= src_r;
               hrdata[`CT_AUTO_SAMPLE_TIME_HI:`CT_AUTO_SAMPLE_TIME_LO] <= auto_sample_time_r;
               hrdata[`CT_DIV_HI:`CT_DIV_LO] <= div_r;
            end
            `OFS_MUX_SEL: begin
               hrdata[`MX_NEG_B] <= neg_b_r;
               hrdata[`MX_POS_B_HI:`MX_POS_B_LO] <= pos_b_r;
               hrdata[`MX_NEG_A] <= neg_a_r;
               hrdata[`MX_POS_A_HI:`MX_POS_A_LO] <= pos_a_r;
            end
            default: begin
               hrdata <= `RST_WORD;
            end
         endcase
      end
   end

   // ************************************************
   // input synchronisers
   // ************************************************
   // three stages; level changes when stages two and three agree
   logic [2:0] raw_in;
   assign raw_in = {conv_done_pin, internal_rc_clock, ext_int_pin};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int k = 0; k < 3; k++) begin
            sync_r[k] <= 3'h0;
         end
         lvl_r <= 3'h0;
      end else begin
         for (int k = 0; k < 3; k++) begin
            sync_r[k] <= {sync_r[k][1:0], raw_in[k]};
            if (sync_r[k][1] == sync_r[k][2]) begin
               lvl_r[k] <= sync_r[k][2];
            end
         end
      end
   end
   logic ext_rise, rc_rise, done_rise;
   logic [2:0] lvl_d_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lvl_d_r <= 3'h0;
      end else begin
         lvl_d_r <= lvl_r;
      end
   end
   assign ext_rise = lvl_r[0] && !lvl_d_r[0];
   assign rc_rise = lvl_r[1] && !lvl_d_r[1];
   assign done_rise = lvl_r[2] && !lvl_d_r[2];

   // ************************************************
   // conversion clock
   // ************************************************
   logic tad_rise;
   assign tad_rise = src_r ? rc_rise : (!conv_clk_r && (div_cnt_r == div_r));
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt_r <= 8'h00;
         conv_clk_r <= 1'b0;
      end else if (src_r) begin
         div_cnt_r <= 8'h00;
         conv_clk_r <= lvl_r[1];
      end else if (div_cnt_r >= div_r) begin
         div_cnt_r <= 8'h00;
         conv_clk_r <= !conv_clk_r;
      end else begin
         div_cnt_r <= div_cnt_r + 8'h01;
      end
   end

   // ************************************************
   // sequencer
   // ************************************************
   logic sw_sample_enable_set, sw_sample_enable_clr, trig_hit, conv_end, irq_now;
   assign sw_sample_enable_set = wr_ctl1 && hwdata[`C1_SAMPLE_ENABLE];
   assign sw_sample_enable_clr = wr_ctl1 && !hwdata[`C1_SAMPLE_ENABLE];
   assign conv_end = (state_r == adc_seq_pkg::ST_CONVERT) && done_rise;
   assign irq_now = conv_end && (seq_cnt_r == spi_r);

   always_comb begin
      unique case (trig_r)
         `TRIG_SOFT: trig_hit = sw_sample_enable_clr;
         `TRIG_EXT_PIN: trig_hit = ext_rise;
         `TRIG_TIMER: trig_hit = timer_match;
         `TRIG_CHARGE: trig_hit = charge_unit_trig;
         `TRIG_COUNTER: trig_hit = tad_rise && ((sample_enable_cnt_r + 5'h01) >= auto_sample_time_r);
         default: trig_hit = 1'b0;
      endcase
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         adc_seq_pkg::ST_IDLE: begin
            if (sw_sample_enable_set && !auto_r) begin
               state_nxt = adc_seq_pkg::ST_SAMPLE;
            end else if (auto_r) begin
               state_nxt = adc_seq_pkg::ST_SAMPLE;
            end
         end
         adc_seq_pkg::ST_SAMPLE: begin
            if (trig_hit) begin
               state_nxt = adc_seq_pkg::ST_CONVERT;
            end
         end
         adc_seq_pkg::ST_CONVERT: begin
            if (conv_end) begin
               if (auto_r && !(irq_now && stop_r)) begin
                  state_nxt = adc_seq_pkg::ST_SAMPLE;
               end else begin
                  state_nxt = adc_seq_pkg::ST_IDLE;
               end
            end
         end
         default: state_nxt = adc_seq_pkg::ST_IDLE;
      endcase
      if (!on_r) begin
         state_nxt = adc_seq_pkg::ST_IDLE;
      end
   end

   // state, sample timer and analog strobes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= adc_seq_pkg::ST_IDLE;
         sample_enable_cnt_r <= 5'h00;
         sampling <= 1'b0;
         conv_start <= 1'b0;
         conv_clock <= 1'b0;
      end else begin
         state_r <= state_nxt;
         sampling <= (state_nxt == adc_seq_pkg::ST_SAMPLE);
         conv_start <= (state_r == adc_seq_pkg::ST_SAMPLE) &&
                       (state_nxt == adc_seq_pkg::ST_CONVERT);
         conv_clock <= conv_clk_r;
         if (state_r != adc_seq_pkg::ST_SAMPLE) begin
            sample_enable_cnt_r <= 5'h00;
         end else if (tad_rise) begin
            sample_enable_cnt_r <= sample_enable_cnt_r + 5'h01;
         end
      end
   end

   // control one register; done also set and auto start also cleared by hardware
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         on_r <= 1'b0;
         form_r <= 3'h0;
         trig_r <= 3'h0;
         stop_r <= 1'b0;
         auto_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         if (wr_ctl1) begin
            on_r <= hwdata[`C1_ON];
            form_r <= hwdata[`C1_FORM_HI:`C1_FORM_LO];
            trig_r <= hwdata[`C1_TRIG_HI:`C1_TRIG_LO];
            stop_r <= hwdata[`C1_STOP];
            auto_r <= hwdata[`C1_AUTO];
         end
         // clear auto start on first interrupt when stop is set
         if (irq_now && stop_r) begin
            auto_r <= 1'b0;
         end
         // completion sets, new conversion and zero write clear
         if (conv_end) begin
            done_r <= 1'b1;
         end else if (conv_start || (wr_ctl1 && !hwdata[`C1_DONE])) begin
            done_r <= 1'b0;
         end
      end
   end

   // control two, timing and mux registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_r <= 3'h0;
         offset_calibration_r <= 1'b0;
         scan_r <= 1'b0;
         spi_r <= 4'h0;
         split_r <= 1'b0;
         alt_r <= 1'b0;
         src_r <= 1'b0;
         auto_sample_time_r <= 5'h00;
         div_r <= 8'h00;
         neg_b_r <= 1'b0;
         pos_b_r <= 5'h00;
         neg_a_r <= 1'b0;
         pos_a_r <= 5'h00;
      end else begin
         if (wr_ctl2) begin
            ref_r <= hwdata[`C2_REF_HI:`C2_REF_LO];
            offset_calibration_r <= hwdata[`C2_OFFSET_CALIBRATION];
            scan_r <= hwdata[`C2_SCAN];
            spi_r <= hwdata[`C2_SPI_HI:`C2_SPI_LO];
            split_r <= hwdata[`C2_SPLIT];
            alt_r <= hwdata[`C2_ALT];
         end
         if (wr_tim) begin
            src_r <= hwdata[`CT_SRC];
            auto_sample_time_r <= hwdata[`CT_AUTO_SAMPLE_TIME_HI:`CT_AUTO_SAMPLE_TIME_LO];
            div_r <= hwdata[`CT_DIV_HI:`CT_DIV_LO];
         end
         if (wr_mux) begin
            neg_b_r <= hwdata[`MX_NEG_B];
            pos_b_r <= hwdata[`MX_POS_B_HI:`MX_POS_B_LO];
            neg_a_r <= hwdata[`MX_NEG_A];
            pos_a_r <= hwdata[`MX_POS_A_HI:`MX_POS_A_LO];
         end
      end
   end

   // ************************************************
   // sequence count, buffer pointer, alternation
   // ************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seq_cnt_r <= 4'h0;
         idx_r <= 4'h0;
         fill_r <= 1'b0;
         use_b_r <= 1'b0;
         result_write <= 1'b0;
         result_index <= 4'h0;
         seq_irq <= 1'b0;
         scan_advance <= 1'b0;
      end else begin
         result_write <= conv_end;
         result_index <= idx_r;
         seq_irq <= irq_now;
         // step the scan on each conversion while scanning is on and offset calibration is off
         scan_advance <= conv_end && scan_r && !offset_calibration_r;
         if (!on_r) begin
            seq_cnt_r <= 4'h0;
            idx_r <= 4'h0;
            fill_r <= 1'b0;
            use_b_r <= 1'b0;
         end else if (conv_end) begin
            use_b_r <= alt_r && !use_b_r;
            if (irq_now) begin
               seq_cnt_r <= 4'h0;
               if (split_r) begin
                  fill_r <= !fill_r;
                  idx_r <= {!fill_r, 3'h0};
               end else begin
                  fill_r <= 1'b0;
                  idx_r <= 4'h0;
               end
            end else begin
               seq_cnt_r <= seq_cnt_r + 4'h1;
               idx_r <= next_idx(idx_r, split_r);
            end
         end
      end
   end

   // ************************************************
   // analog configuration outputs
   // ************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result_format <= 3'h0;
         vrefh_external <= 1'b0;
         vrefl_external <= 1'b0;
         inputs_to_vrefl <= 1'b0;
         positive_select <= 5'h00;
         negative_select <= 1'b0;
         scan_active <= 1'b0;
      end else begin
         result_format <= form_r;
         {vrefl_external, vrefh_external} <= ref_decode(ref_r);
         inputs_to_vrefl <= offset_calibration_r;
         positive_select <= use_b_r ? pos_b_r : pos_a_r;
         negative_select <= offset_calibration_r ? 1'b0 : (use_b_r ? neg_b_r : neg_a_r);
         scan_active <= scan_r && !offset_calibration_r;
      end
   end
endmodule // adc_sequence_control

//--- adc_core_model.sv
module adc_core_model (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // converter handshake
   input wire logic conv_start,
   input wire logic [7:0] delay,
   output logic conv_done_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // analog core: conversion time then done
   // ****************************************
   int cnt;
   // done held four cycles, dropped well before the next conversion ends
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 0;
         conv_done_pin <= 1'b0;
      end else begin
         cnt <= conv_start ? int'(delay) + 4 : (cnt > 0 ? cnt - 1 : 0);
         conv_done_pin <= cnt > 1 && cnt <= 5;
      end
   end
endmodule // adc_core_model

//--- adc_seq_chk.sv
module adc_seq_chk (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // sequencer
   input wire logic sampling,
   input wire logic conv_start,
   input wire logic inputs_to_vrefl,
   input wire logic negative_select,
   input wire logic scan_active,
   input wire logic scan_advance,
   input wire logic result_write,
   input wire logic [3:0] result_index,
   input wire logic seq_irq
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // ****************************************
   // port relations
   // ****************************************
   a_read_wait: assert property (hsel && htrans[1] && !hwrite && hready |=> !hreadyout ##1 hreadyout)
      else $error("read data phase lacks its single wait state");
   a_write_nowait: assert property (hsel && htrans[1] && hwrite && hready |=> hreadyout)
      else $error("write data phase stalled");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_start_ends: assert property (conv_start |-> !sampling && $past(sampling))
      else $error("conversion start without end of sampling");
   a_start_pulse: assert property (conv_start |=> !conv_start)
      else $error("conversion start longer than one cycle");
   a_conv_holds: assert property (conv_start |=> !sampling [*3])
      else $error("sampling resumed before conversion completed");
   a_irq_on_write: assert property (seq_irq |-> result_write)
      else $error("interrupt without completed conversion");
   a_write_pulse: assert property (result_write |=> !result_write)
      else $error("result write longer than one cycle");
   a_calib_inputs: assert property (inputs_to_vrefl |-> !negative_select && !scan_active)
      else $error("calibration does not tie inputs to low reference");
   a_scan_step: assert property (scan_advance |-> scan_active)
      else $error("scan advanced while scanning is off");
   c_start: cover property (conv_start);
   c_irq: cover property (seq_irq);
   c_upper: cover property (result_write && result_index == 4'h8);
endmodule // adc_seq_chk

bind adc_sequence_control adc_seq_chk u_adc_seq_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .sampling(sampling),
   .conv_start(conv_start), .inputs_to_vrefl(inputs_to_vrefl),
   .negative_select(negative_select), .scan_active(scan_active),
   .scan_advance(scan_advance), .result_write(result_write),
   .result_index(result_index), .seq_irq(seq_irq)
);

//--- tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // bench signals and instances
   // ****************************************
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic ext_int_pin = 1'b0;
   logic timer_match = 1'b0;
   logic charge_unit_trig = 1'b0;
   logic internal_rc_clock = 1'b0;
   logic [7:0] core_delay = 8'h02;
   logic hreadyout, hresp, conv_done_pin, sampling, conv_start, conv_clock;
   logic vrefh_external, vrefl_external, inputs_to_vrefl, negative_select;
   logic scan_active, scan_advance, result_write, seq_irq, last_irq, last_adv;
   logic [31:0] hrdata, rdv;
   logic [2:0] result_format;
   logic [4:0] positive_select;
   logic [3:0] result_index, last_idx;
   int mismatches = 0;
   int num_checks = 0;
   int p;
   // bus clock and free-running rc clock
   always #5 hclk = ~hclk;
   always #36 internal_rc_clock = ~internal_rc_clock;

   adc_sequence_control u_adc_sequence_control (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ext_int_pin, .timer_match,
      .charge_unit_trig, .internal_rc_clock, .conv_done_pin, .sampling, .conv_start,
      .conv_clock, .result_format, .vrefh_external, .vrefl_external, .inputs_to_vrefl,
      .positive_select, .negative_select, .scan_active, .scan_advance, .result_write,
      .result_index, .seq_irq
   );
   adc_core_model u_adc_core_model (
      .hclk, .hresetn, .conv_start, .delay(core_delay), .conv_done_pin
   );

   // compare and count
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // one single ahb-lite transfer, read data kept in rdv
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask
   task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(n, e, rdv);
   endtask
   task automatic off();
      xfer(1'b1, 8'h00, 32'h0);
      @(posedge hclk);
   endtask
   // bounded wait for conversion start (0) or result write (1)
   task automatic wait_sig(input int w);
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (!(w == 0 ? conv_start === 1'b1 : result_write === 1'b1) && k < 500);
      last_idx = result_index;
      last_irq = seq_irq;
      last_adv = scan_advance;
      if (k >= 500) chk("wait", 32'h1, 32'h0);
   endtask
   // software sample then convert, mux setting checked while sampling
   task automatic conv_soft(input logic [5:0] e);
      xfer(1'b1, 8'h00, 32'h00008002);
      repeat (3) @(posedge hclk);
      chk("sampling", 32'h1, 32'(sampling));
      chk("mux", 32'(e), 32'({negative_select, positive_select}));
      xfer(1'b1, 8'h00, 32'h00008000);
      wait_sig(0);
      wait_sig(1);
   endtask
   // conversion clock period in bus cycles between two rising edges
   task automatic clk_per(output int q);
      int k, n, t0;
      logic prev;
      k = 0;
      n = 0;
      t0 = 0;
      q = 0;
      prev = conv_clock;
      while (n < 2 && k < 400) begin
         @(posedge hclk);
         k++;
         if (conv_clock === 1'b1 && prev === 1'b0) begin
            n++;
            q = k - t0;
            t0 = k;
         end
         prev = conv_clock;
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 5; i++) rd_chk("reset", 8'(i * 4), 32'h0);
      xfer(1'b1, 8'h04, 32'hfffff4bf);
      rd_chk("ctl2", 8'h04, 32'h0000f43f);
      chk("calib", 32'h4, 32'({inputs_to_vrefl, negative_select, scan_active}));
      xfer(1'b1, 8'h08, 32'hffffffff);
      rd_chk("timing", 8'h08, 32'h00009fff);
      xfer(1'b1, 8'h0c, 32'hffffffff);
      rd_chk("mux", 8'h0c, 32'h9f9f0000);
      xfer(1'b1, 8'h10, 32'hffffffff);
      rd_chk("unmapped", 8'h10, 32'h0);
      xfer(1'b1, 8'h00, 32'h00000500);
      rd_chk("ctl1", 8'h00, 32'h00000500);
      chk("format", 32'h5, 32'(result_format));
      for (int c = 0; c < 8; c++) begin
         xfer(1'b1, 8'h04, 32'(c) << 13);
         repeat (2) @(posedge hclk);
         chk("ref", 32'({c == 1 || c == 3, c == 2 || c == 3}),
             32'({vrefh_external, vrefl_external}));
      end
      xfer(1'b1, 8'h0c, 32'h0);
      xfer(1'b1, 8'h04, 32'h0);
      xfer(1'b1, 8'h08, 32'h00000003);
      xfer(1'b1, 8'h00, 32'h00008000);
      clk_per(p);
      chk("divider", 32'd8, 32'(p));
      xfer(1'b1, 8'h08, 32'h00008020);
      clk_per(p);
      clk_per(p);
      chk("rc", 32'h1, 32'(p > 2 && p < 20));
      xfer(1'b1, 8'h08, 32'h0);
      conv_soft(6'h00);
      rd_chk("done", 8'h00, 32'h00008001);
      xfer(1'b1, 8'h00, 32'h00008003);
      rd_chk("sampdone", 8'h00, 32'h00008003);
      core_delay <= 8'd20;
      xfer(1'b1, 8'h00, 32'h00008001);
      rd_chk("newconv", 8'h00, 32'h00008000);
      wait_sig(1);
      xfer(1'b1, 8'h00, 32'h00008000);
      rd_chk("clear", 8'h00, 32'h00008000);
      xfer(1'b1, 8'h00, 32'h00008001);
      rd_chk("setone", 8'h00, 32'h00008000);
      core_delay <= 8'h02;
      off();
      xfer(1'b1, 8'h04, 32'h00000004);
      xfer(1'b1, 8'h08, 32'h00000200);
      xfer(1'b1, 8'h00, 32'h000080f4);
      for (int i = 0; i < 2; i++) begin
         wait_sig(1);
         chk("index", 32'(i), 32'(last_idx));
         chk("irq", 32'(i == 1), 32'(last_irq));
      end
      rd_chk("stop", 8'h00, 32'h000080f1);
      p = 0;
      repeat (100) begin
         @(posedge hclk);
         p += 32'(conv_start);
      end
      chk("halted", 32'h0, 32'(p));
      off();
      xfer(1'b1, 8'h04, 32'h00000402);
      xfer(1'b1, 8'h00, 32'h00008000);
      conv_soft(6'h00);
      chk("scan", 32'h3, 32'({scan_active, last_adv}));
      chk("lower", 32'h0, 32'(last_idx));
      rd_chk("fill1", 8'h04, 32'h00000482);
      conv_soft(6'h00);
      chk("upper", 32'h8, 32'(last_idx));
      rd_chk("fill0", 8'h04, 32'h00000402);
      off();
      xfer(1'b1, 8'h0c, 32'h9a050000);
      xfer(1'b1, 8'h04, 32'h00000001);
      xfer(1'b1, 8'h00, 32'h00008000);
      for (int i = 0; i < 3; i++) conv_soft(i % 2 ? 6'h3a : 6'h05);
      off();
      xfer(1'b1, 8'h04, 32'h0);
      for (int t = 1; t < 5; t++) begin
         xfer(1'b1, 8'h00, 32'h8000 | (32'(t) << 5));
         xfer(1'b1, 8'h00, 32'h8002 | (32'(t) << 5));
         repeat (4) @(posedge hclk);
         ext_int_pin <= 1'b1;
         timer_match <= t == 2 || t == 4;
         charge_unit_trig <= t == 3 || t == 4;
         @(posedge hclk);
         timer_match <= 1'b0;
         charge_unit_trig <= 1'b0;
         if (t < 4) begin
            wait_sig(0);
            wait_sig(1);
         end else begin
            repeat (30) @(posedge hclk);
            chk("reserved", 32'h1, 32'(sampling));
         end
         ext_int_pin <= 1'b0;
         off();
      end
      end_of_test();
   end

   // watchdog
   initial begin
      repeat (60000) @(posedge hclk);
      mismatches++;
      $display("Error watchdog expected end seen timeout");
      end_of_test();
   end
endmodule // tb_top
